// >>> design/pmu_event_defines.vh
// register offsets, field positions and reset values of the event block
`ifndef PMU_EVENT_DEFINES_VH
`define PMU_EVENT_DEFINES_VH

`define ADDR_FLAGS_A     8'h00
`define ADDR_FLAGS_B     8'h01
`define ADDR_ENABLES_A   8'h02
`define ADDR_ENABLES_B   8'h03
`define RESET_BYTE       8'h00
`define UNMAPPED_BYTE    8'hFF
`define BIT_PENDING      0
`define ENABLES_A_MASK   8'hFE
`define LATCH_A_MASK     8'hE0
`define LIVE_A_MASK      8'h1E
`define PENDING_MASK     8'h01
`define SYNC_W           15

`endif

// >>> design/pmu_event_sync.v
// two-flop synchroniser for a bus of level inputs
`timescale 1ns/1ps
`default_nettype none
module pmu_event_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // levels
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> design/pmu_event_status.v
// event flags, enables and open-drain interrupt of the power-management device
//
// Summary of operation
// RL1 - buck2 overload sets flag A bit 7
// RL2 - buck1 overload sets flag A bit 6
// RL3 - charge done sets flag A bit 5
// RL4 - bits 4..1 mirror live states, change interrupts
// RL5 - flags A at 0x00, bit 0 pending
// RL6 - flags B latch switch and buck3 overloads
// RL7 - flags B at 0x01, read-only
// RL8 - enables A at 0x02, bit 0 reserved
// RL9 - writing 0 to pending clears latches
// RL10 - interrupt pin pulled low, otherwise released
// RL11 - flags refresh only when interrupt occurs
// RL12 - undervoltage reset restores every default
// RL13 - enabled OR of events raises interrupt
// RL14 - read-only writes ignored, reserved reads zero
`timescale 1ns/1ps
`default_nettype none
`include "pmu_event_defines.vh"
module pmu_event_status (
  // clock and undervoltage reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // event sources from the analog side
  input  wire       buck1_overload_i,
  input  wire       buck2_overload_i,
  input  wire       buck3_overload_i,
  input  wire       charge_done_i,
  input  wire       charge_active_i,
  input  wire       battery_good_i,
  input  wire       system_rail_good_i,
  input  wire       adapter_good_i,
  input  wire [6:0] switch_overload_i,
  // register port from the serial slave engine
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  // open-drain interrupt pin, oe low means pulled low
  output reg        irq_pin_o,
  output reg        irq_pin_oe_n_o
);
  // ------------------------------------------------------------
  // synchronise the analog sources
  // ------------------------------------------------------------
  wire [`SYNC_W-1:0] src_s;
  pmu_event_sync #(.W(`SYNC_W)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({switch_overload_i, buck3_overload_i, buck2_overload_i, buck1_overload_i,
               charge_done_i, charge_active_i, battery_good_i, system_rail_good_i, adapter_good_i}),
    .sync_o  (src_s)
  );
  // live view of flags A (bit 0 slot unused) and flags B
  wire [7:0] live_a = {src_s[6], src_s[5], src_s[4], src_s[3], src_s[2], src_s[1], src_s[0], 1'b0};
  wire [7:0] live_b = {src_s[14:8], src_s[7]};

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [7:0] flags_a_q;
  reg  [7:0] flags_b_q;
  reg  [7:0] enables_a_q;
  reg  [7:0] enables_b_q;
  reg  [7:0] prev_a_q;
  reg  [7:0] prev_b_q;

  // rising edges for latched bits, any edge for live bits
  wire [7:0] rise_a  = live_a & ~prev_a_q & `LATCH_A_MASK;
  wire [7:0] chg_a   = (live_a ^ prev_a_q) & `LIVE_A_MASK;
  wire [7:0] rise_b  = live_b & ~prev_b_q;
  wire [7:0] trig_a  = (rise_a | chg_a) & enables_a_q;
  wire [7:0] trig_b  = rise_b & enables_b_q;
  wire       event_s = |{trig_a, trig_b};
  wire       pending = flags_a_q[`BIT_PENDING];
  wire       clr_wr  = reg_wr_i && (reg_addr_i == `ADDR_FLAGS_A) && !reg_wdata_i[`BIT_PENDING];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_a_q   <= `RESET_BYTE; // RL12
      flags_b_q   <= `RESET_BYTE; // RL12
      enables_a_q <= `RESET_BYTE; // RL12
      enables_b_q <= `RESET_BYTE; // RL12
      prev_a_q    <= `RESET_BYTE;
      prev_b_q    <= `RESET_BYTE;
    end else begin
      prev_a_q <= live_a;
      prev_b_q <= live_b;
      if (event_s) begin
        // snapshot taken only on an interrupt; new events win over a clear
        flags_a_q <= ((flags_a_q & `LATCH_A_MASK & {8{!clr_wr}}) | (live_a & `LATCH_A_MASK)
                     | (live_a & `LIVE_A_MASK)) | `PENDING_MASK; // RL1 RL2 RL3 RL4 RL11 RL13
        flags_b_q <= (flags_b_q & {8{!clr_wr}}) | live_b; // RL6 RL11
      end else if (clr_wr) begin
        // pending and overload/charge-done latches drop together
        flags_a_q <= flags_a_q & `LIVE_A_MASK; // RL9 RL5
        flags_b_q <= `RESET_BYTE; // RL9
      end
      if (reg_wr_i && reg_addr_i == `ADDR_ENABLES_A) begin
        enables_a_q <= reg_wdata_i & `ENABLES_A_MASK; // RL8 RL14
      end
      if (reg_wr_i && reg_addr_i == `ADDR_ENABLES_B) begin
        enables_b_q <= reg_wdata_i; // RL13
      end
    end
  end

  // ------------------------------------------------------------
  // read data and interrupt pin
  // ------------------------------------------------------------
  reg [7:0] rdata_d;
  always @* begin
    case (reg_addr_i)
      `ADDR_FLAGS_A:   rdata_d = flags_a_q; // RL5
      `ADDR_FLAGS_B:   rdata_d = flags_b_q; // RL7
      `ADDR_ENABLES_A: rdata_d = enables_a_q & `ENABLES_A_MASK; // RL14
      `ADDR_ENABLES_B: rdata_d = enables_b_q;
      default:         rdata_d = `UNMAPPED_BYTE;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o    <= `RESET_BYTE;
      irq_pin_o      <= 1'b0;
      irq_pin_oe_n_o <= 1'b1;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
      // driven output is constant low; high level comes from the pull-up
      irq_pin_o      <= 1'b0;
      irq_pin_oe_n_o <= !(event_s || (pending && !clr_wr)); // RL10
    end
  end
endmodule
`default_nettype wire

// >>> sim/pmu_host_model.sv
// host side of the interrupt line: external pull-up
`timescale 1ns/1ps
`default_nettype none
module pmu_host_model (
  input  wire logic irq_pin_i,
  input  wire logic irq_pin_oe_n_i,
  output wire logic irq_line_o
);
  // line floats high unless the device pulls it
  assign irq_line_o = irq_pin_oe_n_i ? 1'b1 : irq_pin_i;
endmodule
`default_nettype wire

// >>> sim/pmu_event_monitor.sv
// assertions on the event block ports
`timescale 1ns/1ps
`default_nettype none
module pmu_event_monitor (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // register port
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // interrupt pin
  input wire logic       irq_pin_o,
  input wire logic       irq_pin_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_pin; irq_pin_o == 1'b0; endproperty
  a_pin: assert property (p_pin) else $error("pin driven high");
  property p_pend; reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[0] == !$past(irq_pin_oe_n_o); endproperty
  a_pend: assert property (p_pend) else $error("pending bit wrong");
  property p_rsv; reg_rd_i && reg_addr_i == 8'h02 |=> !reg_rdata_o[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_unm; reg_rd_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 8'hFF; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read wrong");
  // a pulled pin stays pulled until the host writes the clear
  property p_hold;
    !irq_pin_oe_n_o && !(reg_wr_i && reg_addr_i == 8'h00 && !reg_wdata_i[0]) |=> !irq_pin_oe_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped without clear");
  property p_rel;
    $rose(irq_pin_oe_n_o) |-> $past(reg_wr_i) && $past(reg_addr_i) == 8'h00 && ($past(reg_wdata_i) & 8'h01) == 8'h00;
  endproperty
  a_rel: assert property (p_rel) else $error("interrupt released without clear");
endmodule
bind pmu_event_status pmu_event_monitor i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .irq_pin_o(irq_pin_o), .irq_pin_oe_n_o(irq_pin_oe_n_o));
`default_nettype wire

// >>> sim/test_pmu_event_status.sv
// register and event tests of the event block
`timescale 1ns/1ps
`default_nettype none
module test_pmu_event_status;
  logic       clk_i = 0, rst_n_i = 0, wr = 0, rd = 0;
  logic [7:0] src = 0;
  logic [6:0] sw = 0;
  logic [7:0] addr = 0, wd = 0;
  wire  [7:0] rdata;
  wire        pin, oe_n, line;
  int         err_total = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  pmu_event_status i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .buck1_overload_i(src[0]), .buck2_overload_i(src[1]),
    .buck3_overload_i(src[3]), .charge_done_i(src[4]), .charge_active_i(src[5]), .battery_good_i(src[6]),
    .system_rail_good_i(src[7]), .adapter_good_i(src[2]), .switch_overload_i(sw), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .irq_pin_o(pin), .irq_pin_oe_n_o(oe_n));
  pmu_host_model i_host (.irq_pin_i(pin), .irq_pin_oe_n_i(oe_n), .irq_line_o(line));
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s %h expected %h seen %h", n, addr, e, s);
    end
  endtask
  task automatic wrr(input logic [7:0] a, d);
    @(posedge clk_i) begin wr <= 1; addr <= a; wd <= d; end
    @(posedge clk_i) wr <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    @(posedge clk_i) begin rd <= 1; addr <= a; end
    @(posedge clk_i) rd <= 0;
    #1 chk("reg", rdata, e);
  endtask
  // sources pass two sync flops, so five edges is ample
  task automatic ev(input logic [7:0] s, input logic [6:0] w);
    @(posedge clk_i) begin src <= s; sw <= w; end
    repeat (5) @(posedge clk_i);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1;
    rdc(8'h00, 8'h00);
    rdc(8'h01, 8'h00);
    wrr(8'h01, 8'hFF);
    rdc(8'h01, 8'h00);
    wrr(8'h02, 8'hFF);
    rdc(8'h02, 8'hFE);
    rdc(8'h10, 8'hFF);
    $display("register test done");
    wrr(8'h02, 8'h80);
    ev(8'h01, 7'h00);
    rdc(8'h00, 8'h00);
    chk("irq", {7'h0, line}, 8'h01);
    ev(8'h00, 7'h00);
    ev(8'h02, 7'h00);
    rdc(8'h00, 8'h81);
    chk("irq", {7'h0, line}, 8'h00);
    wrr(8'h00, 8'h00);
    ev(8'h00, 7'h00);
    rdc(8'h00, 8'h00);
    chk("irq", {7'h0, line}, 8'h01);
    wrr(8'h03, 8'h02);
    ev(8'h00, 7'h01);
    rdc(8'h01, 8'h02);
    wrr(8'h00, 8'h00);
    ev(8'h00, 7'h00);
    rdc(8'h01, 8'h00);
    wrr(8'h02, 8'h02);
    ev(8'h04, 7'h00);
    rdc(8'h00, 8'h03);
    wrr(8'h00, 8'hFF);
    rdc(8'h00, 8'h03);
    chk("irq", {7'h0, line}, 8'h00);
    wrr(8'h00, 8'h00);
    rdc(8'h00, 8'h02);
    wrr(8'h02, 8'hFE);
    ev(8'h05, 7'h00);
    rdc(8'h00, 8'h43);
    wrr(8'h00, 8'h00);
    ev(8'h14, 7'h00);
    rdc(8'h00, 8'h23);
    wrr(8'h00, 8'h00);
    ev(8'h64, 7'h00);
    rdc(8'h00, 8'h1B);
    wrr(8'h00, 8'h00);
    ev(8'hE0, 7'h00);
    rdc(8'h00, 8'h1D);
    wrr(8'h00, 8'h00);
    ev(8'hE0, 7'h02);
    rdc(8'h01, 8'h00);
    rdc(8'h00, 8'h1C);
    chk("irq", {7'h0, line}, 8'h01);
    wrr(8'h03, 8'hFF);
    ev(8'hE8, 7'h7F);
    rdc(8'h01, 8'hFF);
    wrr(8'h00, 8'h00);
    rdc(8'h01, 8'h00);
    $display("event test done");
    @(posedge clk_i) rst_n_i <= 0;
    @(posedge clk_i) rst_n_i <= 1;
    rdc(8'h02, 8'h00);
    rdc(8'h00, 8'h00);
    rdc(8'h03, 8'h00);
    chk("irq", {7'h0, line}, 8'h01);
    $display("reset test done");
    finish_test;
  end
endmodule
`default_nettype wire
